// ---- hw/port_pin_override_pkg.sv ----
// Constants shared by the port pin override logic
package port_pin_override_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned PIN_COUNT_DEFAULT = 8;
  localparam int unsigned ADDR_W            = 3;
  localparam int unsigned DATA_W            = 8;
  localparam int unsigned SLEEP_MODE_W      = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] DIRECTION_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] LATCH_OFS     = 3'h1;
  localparam logic [ADDR_W-1:0] PIN_READ_OFS  = 3'h2;
  localparam logic [ADDR_W-1:0] PORT_CTRL_OFS = 3'h3;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned        PUD_BIT         = 0;
  localparam logic [DATA_W-1:0]  DIRECTION_RST   = 8'h00;
  localparam logic [DATA_W-1:0]  LATCH_RST       = 8'h00;
  localparam logic               PUD_RST         = 1'h0;
  localparam logic [DATA_W-1:0]  UNMAPPED_READ   = 8'h00;

  // ****************************************************************
  // Sleep controller mode codes
  // ****************************************************************
  localparam logic [SLEEP_MODE_W-1:0] SLEEP_IDLE        = 3'h0;
  localparam logic [SLEEP_MODE_W-1:0] SLEEP_ADC_NR      = 3'h1;
  localparam logic [SLEEP_MODE_W-1:0] SLEEP_POWER_DOWN  = 3'h2;
  localparam logic [SLEEP_MODE_W-1:0] SLEEP_POWER_SAVE  = 3'h3;
  localparam logic [SLEEP_MODE_W-1:0] SLEEP_STANDBY     = 3'h6;
  localparam logic [SLEEP_MODE_W-1:0] SLEEP_EXT_STANDBY = 3'h7;

endpackage

// ---- hw/pin_override_cell.sv ----
// Per-pin override multiplexer for one general-purpose I/O pin
`timescale 1ns/1ps
`default_nettype none

module pin_override_cell (
  // Port register bits
  input  wire logic i_direction_bit,
  input  wire logic i_output_latch_bit,
  // Shared controls
  input  wire logic i_global_pullup_disable,
  input  wire logic i_sleep_clamp,
  // Overrides from the owning peripheral
  input  wire logic i_pullup_override_enable,
  input  wire logic i_pullup_override_level,
  input  wire logic i_direction_override_enable,
  input  wire logic i_direction_override_level,
  input  wire logic i_value_override_enable,
  input  wire logic i_value_override_level,
  input  wire logic i_input_enable_override_enable,
  input  wire logic i_input_enable_override_level,
  // Pad controls
  output logic      o_pullup_en,
  output logic      o_driver_en,
  output logic      o_drive_value,
  output logic      o_input_en
);

  logic default_pullup;

  // (RL1) Default pull-up term
  assign default_pullup = ~i_direction_bit & i_output_latch_bit & ~i_global_pullup_disable;

  always_comb begin
    // (RL2) Pull-up override select
    if (i_pullup_override_enable) begin
      o_pullup_en = i_pullup_override_level;
    end else begin
      o_pullup_en = default_pullup;
    end
    // (RL3) Direction override select
    if (i_direction_override_enable) begin
      o_driver_en = i_direction_override_level;
    end else begin
      // (RL4) Direction from register
      o_driver_en = i_direction_bit;
    end
    // (RL5) Value override select
    if (i_value_override_enable) begin
      o_drive_value = i_value_override_level;
    end else begin
      // (RL6) Value from latch
      o_drive_value = i_output_latch_bit;
    end
    // (RL8) Input enable override
    if (i_input_enable_override_enable) begin
      o_input_en = i_input_enable_override_level;
    end else begin
      // (RL9) Input enable from sleep
      o_input_en = ~i_sleep_clamp;
    end
  end

endmodule

`default_nettype wire

// ---- hw/port_pin_override_mux.sv ----
// Port with alternate-function overrides, register port and pad drive
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Function
// (RL1) Default pull-up when input, latch high, enabled
// (RL2) Pull-up override follows its level
// (RL3) Direction override sets driver enable
// (RL4) Otherwise driver enable from direction bit
// (RL5) Value override drives override level
// (RL6) Otherwise driver drives output latch bit
// (RL7) Toggle override inverts stored latch bit
// (RL8) Input enable override sets input enable
// (RL9) Otherwise input enable from sleep state
// (RL10) Raw input taken before the synchroniser
// (RL11) Peripheral synchronises raw input itself
// (RL12) Analog link wired straight to pad
// (RL13) Strobes per port, sleep and disable global
// (RL14) Peripherals generate their own override signals
// (RL15) Pin n is converter and change source n
// (RL16) Writing one to pin read toggles latch
// (RL17) Sleep clamps in power-down, save, standby
// (RL18) Inactive alternate function forces overrides low
module port_pin_override_mux #(
  parameter int unsigned PIN_COUNT = port_pin_override_pkg::PIN_COUNT_DEFAULT
) (
  // Clock and reset
  input  wire logic                                         i_mclk,
  input  wire logic                                         i_rst_b,
  // Register port
  input  wire logic [port_pin_override_pkg::ADDR_W-1:0]      i_addr,
  input  wire logic [port_pin_override_pkg::DATA_W-1:0]      i_wdata,
  input  wire logic                                         i_wr,
  input  wire logic                                         i_rd,
  output logic      [port_pin_override_pkg::DATA_W-1:0]      o_rdata,
  // Sleep controller
  input  wire logic                                         i_sleeping,
  input  wire logic [port_pin_override_pkg::SLEEP_MODE_W-1:0] i_sleep_mode,
  // Peripheral overrides, one bit per pin
  input  wire logic [PIN_COUNT-1:0]                         i_alt_active,
  input  wire logic [PIN_COUNT-1:0]                         i_pullup_override_enable,
  input  wire logic [PIN_COUNT-1:0]                         i_pullup_override_level,
  input  wire logic [PIN_COUNT-1:0]                         i_direction_override_enable,
  input  wire logic [PIN_COUNT-1:0]                         i_direction_override_level,
  input  wire logic [PIN_COUNT-1:0]                         i_value_override_enable,
  input  wire logic [PIN_COUNT-1:0]                         i_value_override_level,
  input  wire logic [PIN_COUNT-1:0]                         i_latch_toggle_override,
  input  wire logic [PIN_COUNT-1:0]                         i_input_enable_override_enable,
  input  wire logic [PIN_COUNT-1:0]                         i_input_enable_override_level,
  // Pad side
  input  wire logic [PIN_COUNT-1:0]                         i_pad_in,
  output logic      [PIN_COUNT-1:0]                         o_pad_out,
  output logic      [PIN_COUNT-1:0]                         o_pad_oe,
  output logic      [PIN_COUNT-1:0]                         o_pullup_en,
  output logic      [PIN_COUNT-1:0]                         o_input_enable,
  // Peripheral inputs
  output logic      [PIN_COUNT-1:0]                         o_raw_alternate_input,
  output logic      [PIN_COUNT-1:0]                         o_pin_change_irq_sources,
  // Analog link
  input  wire logic [PIN_COUNT-1:0]                         i_analog_pad_link_pad,
  output logic      [PIN_COUNT-1:0]                         o_analog_pad_link_adc,
  input  wire logic [PIN_COUNT-1:0]                         i_analog_pad_link_periph,
  output logic      [PIN_COUNT-1:0]                         o_analog_pad_link_drive
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  generate
    if (PIN_COUNT < 1 || PIN_COUNT > port_pin_override_pkg::DATA_W) begin : g_bad_width
      $error("PIN_COUNT must be between 1 and the data width");
    end
  endgenerate

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [PIN_COUNT-1:0] direction_reg;
  logic [PIN_COUNT-1:0] latch_reg;
  logic [PIN_COUNT-1:0] latch_next;
  logic                 pud_reg;
  logic [PIN_COUNT-1:0] sync1_reg;
  logic [PIN_COUNT-1:0] sync2_reg;
  logic [PIN_COUNT-1:0] sync3_reg;
  logic [PIN_COUNT-1:0] pin_read_reg;
  logic                 sleep_clamp;
  logic [PIN_COUNT-1:0] ovr_pu_en;
  logic [PIN_COUNT-1:0] ovr_dir_en;
  logic [PIN_COUNT-1:0] ovr_val_en;
  logic [PIN_COUNT-1:0] ovr_toggle;
  logic [PIN_COUNT-1:0] ovr_ie_en;
  logic [PIN_COUNT-1:0] pullup_comb;
  logic [PIN_COUNT-1:0] driver_comb;
  logic [PIN_COUNT-1:0] value_comb;
  logic [PIN_COUNT-1:0] input_en_comb;
  logic [PIN_COUNT-1:0] input_en_reg;
  logic [PIN_COUNT-1:0] pin_toggle_wr;
  logic                 wr_direction;
  logic                 wr_latch;
  logic                 wr_pin_read;
  logic                 wr_ctrl;
  logic [port_pin_override_pkg::DATA_W-1:0] rdata_next;

  // ****************************************************************
  // Override gating
  // ****************************************************************
  // (RL18) Overrides held low when inactive
  assign ovr_pu_en  = i_pullup_override_enable       & i_alt_active;
  assign ovr_dir_en = i_direction_override_enable    & i_alt_active;
  assign ovr_val_en = i_value_override_enable        & i_alt_active;
  assign ovr_toggle = i_latch_toggle_override        & i_alt_active;
  assign ovr_ie_en  = i_input_enable_override_enable & i_alt_active;

  // ****************************************************************
  // Sleep clamp decode
  // ****************************************************************
  always_comb begin
    // (RL17) Clamp only in deep sleep modes
    sleep_clamp = 1'b0;
    if (i_sleeping) begin
      if (i_sleep_mode == port_pin_override_pkg::SLEEP_POWER_DOWN) begin
        sleep_clamp = 1'b1;
      end else if (i_sleep_mode == port_pin_override_pkg::SLEEP_POWER_SAVE) begin
        sleep_clamp = 1'b1;
      end else if (i_sleep_mode == port_pin_override_pkg::SLEEP_STANDBY) begin
        sleep_clamp = 1'b1;
      end
    end
  end

  // ****************************************************************
  // Per-pin override cells
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      // (RL13) Shared controls, per-pin overrides
      pin_override_cell u_cell (
        .i_direction_bit                (direction_reg[gi]),
        .i_output_latch_bit             (latch_reg[gi]),
        .i_global_pullup_disable        (pud_reg),
        .i_sleep_clamp                  (sleep_clamp),
        .i_pullup_override_enable       (ovr_pu_en[gi]),
        .i_pullup_override_level        (i_pullup_override_level[gi]),
        .i_direction_override_enable    (ovr_dir_en[gi]),
        .i_direction_override_level     (i_direction_override_level[gi]),
        .i_value_override_enable        (ovr_val_en[gi]),
        .i_value_override_level         (i_value_override_level[gi]),
        .i_input_enable_override_enable (ovr_ie_en[gi]),
        .i_input_enable_override_level  (i_input_enable_override_level[gi]),
        .o_pullup_en                    (pullup_comb[gi]),
        .o_driver_en                    (driver_comb[gi]),
        .o_drive_value                  (value_comb[gi]),
        .o_input_en                     (input_en_comb[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Register write decode
  // ****************************************************************
  always_comb begin
    wr_direction = 1'b0;
    wr_latch     = 1'b0;
    wr_pin_read  = 1'b0;
    wr_ctrl      = 1'b0;
    if (i_wr && i_addr == port_pin_override_pkg::DIRECTION_OFS) begin
      wr_direction = 1'b1;
    end else if (i_wr && i_addr == port_pin_override_pkg::LATCH_OFS) begin
      wr_latch = 1'b1;
    end else if (i_wr && i_addr == port_pin_override_pkg::PIN_READ_OFS) begin
      wr_pin_read = 1'b1;
    end else if (i_wr && i_addr == port_pin_override_pkg::PORT_CTRL_OFS) begin
      wr_ctrl = 1'b1;
    end
  end

  // (RL16) Pin read write toggles latch
  assign pin_toggle_wr = wr_pin_read ? i_wdata[PIN_COUNT-1:0] : '0;

  // ****************************************************************
  // Port registers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      direction_reg <= port_pin_override_pkg::DIRECTION_RST[PIN_COUNT-1:0];
    end else if (wr_direction) begin
      direction_reg <= i_wdata[PIN_COUNT-1:0];
    end
  end

  always_comb begin
    latch_next = latch_reg;
    if (wr_latch) begin
      latch_next = i_wdata[PIN_COUNT-1:0];
    end
    // (RL7) Toggle override inverts latch
    latch_next = latch_next ^ (pin_toggle_wr | ovr_toggle);
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      latch_reg <= port_pin_override_pkg::LATCH_RST[PIN_COUNT-1:0];
    end else begin
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pud_reg <= port_pin_override_pkg::PUD_RST;
    end else if (wr_ctrl) begin
      pud_reg <= i_wdata[port_pin_override_pkg::PUD_BIT];
    end
  end

  // ****************************************************************
  // Pad drive outputs
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pad_oe       <= '0;
      o_pad_out      <= '0;
      o_pullup_en    <= '0;
      o_input_enable <= '0;
      input_en_reg   <= '0;
    end else begin
      o_pad_oe       <= driver_comb;
      o_pad_out      <= value_comb & driver_comb;
      o_pullup_en    <= pullup_comb;
      o_input_enable <= input_en_comb;
      input_en_reg   <= input_en_comb;
    end
  end

  // ****************************************************************
  // Digital input path
  // ****************************************************************
  // (RL10) Clamped pad value, unsynchronised
  assign o_raw_alternate_input = i_pad_in & input_en_reg;
  // (RL15) Pin n feeds change source n
  assign o_pin_change_irq_sources = o_raw_alternate_input;

  // Raw value reaches peripherals unsynchronised; they synchronise it
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= o_raw_alternate_input;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Accept a change only once the last two stages agree
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_read_reg <= '0;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_read_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // ****************************************************************
  // Analog link
  // ****************************************************************
  // (RL12) Analog path bypasses digital logic
  assign o_analog_pad_link_adc   = i_analog_pad_link_pad;
  assign o_analog_pad_link_drive = i_analog_pad_link_periph;

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_comb begin
    rdata_next = port_pin_override_pkg::UNMAPPED_READ;
    if (i_addr == port_pin_override_pkg::DIRECTION_OFS) begin
      rdata_next[PIN_COUNT-1:0] = direction_reg;
    end else if (i_addr == port_pin_override_pkg::LATCH_OFS) begin
      rdata_next[PIN_COUNT-1:0] = latch_reg;
    end else if (i_addr == port_pin_override_pkg::PIN_READ_OFS) begin
      rdata_next[PIN_COUNT-1:0] = pin_read_reg;
    end else if (i_addr == port_pin_override_pkg::PORT_CTRL_OFS) begin
      rdata_next[port_pin_override_pkg::PUD_BIT] = pud_reg;
    end
  end

  // Read data stand for exactly one cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= '0;
    end
  end

endmodule

`default_nettype wire

// ---- bench/port_pin_override_mux_assertions.sv ----
// Port-level checks for the port pin override mux
`timescale 1ns/1ps
`default_nettype none
module port_pin_override_mux_assertions #(
  parameter int unsigned PIN_COUNT = 8
) (
  // Clock, reset and register port
  input wire logic                 i_mclk,
  input wire logic                 i_rst_b,
  input wire logic [2:0]           i_addr,
  input wire logic                 i_rd,
  input wire logic [7:0]           o_rdata,
  // Sleep controller
  input wire logic                 i_sleeping,
  input wire logic [2:0]           i_sleep_mode,
  // Overrides
  input wire logic [PIN_COUNT-1:0] i_alt_active,
  input wire logic [PIN_COUNT-1:0] i_pullup_override_enable,
  input wire logic [PIN_COUNT-1:0] i_pullup_override_level,
  input wire logic [PIN_COUNT-1:0] i_direction_override_enable,
  input wire logic [PIN_COUNT-1:0] i_direction_override_level,
  input wire logic [PIN_COUNT-1:0] i_value_override_enable,
  input wire logic [PIN_COUNT-1:0] i_value_override_level,
  input wire logic [PIN_COUNT-1:0] i_input_enable_override_enable,
  input wire logic [PIN_COUNT-1:0] i_input_enable_override_level,
  // Pad side
  input wire logic [PIN_COUNT-1:0] i_pad_in,
  input wire logic [PIN_COUNT-1:0] o_pad_out,
  input wire logic [PIN_COUNT-1:0] o_pad_oe,
  input wire logic [PIN_COUNT-1:0] o_pullup_en,
  input wire logic [PIN_COUNT-1:0] o_input_enable,
  input wire logic [PIN_COUNT-1:0] o_raw_alternate_input
);
  logic arm_reg;
  logic live_reg;
  logic clamp;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  assign clamp = i_sleeping && (i_sleep_mode == 3'h2 || i_sleep_mode == 3'h3 || i_sleep_mode == 3'h6);
  // Skips the first two edges after reset; the first of them has history from reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arm_reg  <= 1'b0;
      live_reg <= 1'b0;
    end else begin
      arm_reg  <= 1'b1;
      live_reg <= arm_reg;
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b || !live_reg);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_pullup_override: assert property (
    ((o_pullup_en ^ $past(i_pullup_override_level)) & $past(i_alt_active)
      & $past(i_pullup_override_enable)) == '0) else $error("pull-up ignores override");
  a_driver_override: assert property (
    ((o_pad_oe ^ $past(i_direction_override_level)) & $past(i_alt_active)
      & $past(i_direction_override_enable)) == '0) else $error("driver ignores override");
  a_value_override: assert property (
    ((o_pad_out ^ $past(i_value_override_level)) & o_pad_oe & $past(i_alt_active)
      & $past(i_value_override_enable)) == '0) else $error("drive value ignores override");
  a_input_override: assert property (
    ((o_input_enable ^ $past(i_input_enable_override_level)) & $past(i_alt_active)
      & $past(i_input_enable_override_enable)) == '0) else $error("input enable ignores override");
  a_input_sleep_clamp: assert property (
    ((o_input_enable ^ {PIN_COUNT{!$past(clamp)}}) & ~($past(i_alt_active)
      & $past(i_input_enable_override_enable))) == '0) else $error("input enable wrong in sleep");
  a_raw_input_path: assert property (
    o_raw_alternate_input == (i_pad_in & o_input_enable)) else $error("raw input path wrong");
  a_pad_out_gated: assert property (
    (o_pad_out & ~o_pad_oe) == '0) else $error("pad driven while driver off");
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside its cycle");
  a_unmapped_read: assert property (
    $past(i_rd) && $past(i_addr) > 3'h3 |-> o_rdata == 8'h00) else $error("unmapped read not 0");
endmodule
bind port_pin_override_mux port_pin_override_mux_assertions #(.PIN_COUNT(PIN_COUNT)) i_chk (.*);
`default_nettype wire

// ---- bench/alt_periph_model.sv ----
// Behavioural peripheral owning the alternate functions of the port pins
`timescale 1ns/1ps
`default_nettype none
module alt_periph_model (
  // Clock, reset and command from the bench
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  input  wire logic [71:0] i_cmd,
  // Raw input from the port
  input  wire logic [7:0]  i_raw,
  // Override pairs to the port and synchronised input
  output logic      [71:0] o_ovr,
  output logic      [7:0]  o_raw_sync
);
  logic [7:0] sync1_reg;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ovr <= 72'h0;
    end else begin
      o_ovr <= i_cmd;
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_reg  <= 8'h00;
      o_raw_sync <= 8'h00;
    end else begin
      sync1_reg  <= i_raw;
      o_raw_sync <= sync1_reg;
    end
  end
endmodule
`default_nettype wire

// ---- bench/port_pin_override_mux_tb_top.sv ----
// Self-checking bench for the port pin override mux
`timescale 1ns/1ps
`default_nettype none
module port_pin_override_mux_tb_top;
  logic        mclk, rst_b, wr, rd, sleeping, global_pullup_disable;
  logic [2:0]  addr, mode;
  logic [7:0]  wdata, alt, pad, apad, aper, rdata, pout, poe, pue, ien, raw, irq, adc, drv;
  logic [7:0]  dir, lat, rsync;
  logic [71:0] cmd, ovr;
  logic [95:0] r;
  int          fails, n_checks;

  port_pin_override_mux i_port_pin_override_mux (.i_mclk(mclk), .i_rst_b(rst_b),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_sleeping(sleeping), .i_sleep_mode(mode), .i_alt_active(alt),
    .i_pullup_override_enable(ovr[7:0]), .i_pullup_override_level(ovr[15:8]),
    .i_direction_override_enable(ovr[23:16]), .i_direction_override_level(ovr[31:24]),
    .i_value_override_enable(ovr[39:32]), .i_value_override_level(ovr[47:40]),
    .i_latch_toggle_override(ovr[55:48]), .i_input_enable_override_enable(ovr[63:56]),
    .i_input_enable_override_level(ovr[71:64]), .i_pad_in(pad), .o_pad_out(pout),
    .o_pad_oe(poe), .o_pullup_en(pue), .o_input_enable(ien), .o_raw_alternate_input(raw),
    .o_pin_change_irq_sources(irq), .i_analog_pad_link_pad(apad),
    .o_analog_pad_link_adc(adc), .i_analog_pad_link_periph(aper),
    .o_analog_pad_link_drive(drv));
  alt_periph_model i_alt_periph_model (.i_mclk(mclk), .i_rst_b(rst_b), .i_cmd(cmd),
    .i_raw(raw), .o_ovr(ovr), .o_raw_sync(rsync));

  // ****************************************************************
  // Expectations
  // ****************************************************************
  function automatic logic [7:0] f(int k);
    return cmd[8*k+:8];
  endfunction
  function automatic logic [7:0] en(int k);
    return cmd[8*k+:8] & alt;
  endfunction
  function automatic logic [7:0] oe_e();
    return (en(2) & f(3)) | (~en(2) & dir);
  endfunction
  function automatic logic [7:0] ie_e();
    logic c;
    c = sleeping && (mode == port_pin_override_pkg::SLEEP_POWER_DOWN
      || mode == port_pin_override_pkg::SLEEP_POWER_SAVE
      || mode == port_pin_override_pkg::SLEEP_STANDBY);
    return (en(7) & f(8)) | (~en(7) & {8{~c}});
  endfunction
  function automatic logic [7:0] reg_e(logic [2:0] a);
    case (a)
      port_pin_override_pkg::DIRECTION_OFS: return dir;
      port_pin_override_pkg::LATCH_OFS: return lat;
      port_pin_override_pkg::PIN_READ_OFS: return pad & ie_e();
      port_pin_override_pkg::PORT_CTRL_OFS: return {7'h00, global_pullup_disable};
      default: return port_pin_override_pkg::UNMAPPED_READ;
    endcase
  endfunction

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
    case (a)
      port_pin_override_pkg::DIRECTION_OFS: dir = d;
      port_pin_override_pkg::LATCH_OFS: lat = d;
      port_pin_override_pkg::PIN_READ_OFS: lat = lat ^ d;
      port_pin_override_pkg::PORT_CTRL_OFS: global_pullup_disable = d[0];
      default: ;
    endcase
  endtask
  task automatic rd_all();
    for (int a = 0; a < 8; a++) begin
      addr <= 3'(a);
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(rdata, reg_e(3'(a)));
      @(posedge mclk);
    end
  endtask
  task automatic settle(input string name);
    repeat (3) @(posedge mclk);
    #1;
    chk(pue, (en(0) & f(1)) | (~en(0) & ~dir & lat & {8{~global_pullup_disable}}));
    chk(poe, oe_e());
    chk(pout, oe_e() & ((en(4) & f(5)) | (~en(4) & lat)));
    chk(ien, ie_e());
    chk(raw, pad & ie_e());
    chk(irq, pad & ie_e());
    chk(rsync, pad & ie_e());
    chk(adc, apad);
    chk(drv, aper);
    @(posedge mclk);
    $display("test %s done", name);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test();
  end
  initial begin
    {rst_b, wr, rd, sleeping, global_pullup_disable} = 5'h00;
    {addr, mode, wdata, alt, pad, apad, aper, cmd} = '0;
    dir = port_pin_override_pkg::DIRECTION_RST;
    lat = port_pin_override_pkg::LATCH_RST;
    fails = 0;
    n_checks = 0;
    void'($urandom(32'hFBED7964));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rd_all();
    for (int a = 4; a < 8; a++) wr_reg(3'(a), 8'hFF);
    rd_all();
    for (int m = 0; m < 8; m++) begin
      sleeping <= 1'b1;
      mode <= 3'(m);
      settle("sleep mode");
    end
    sleeping <= 1'b0;
    wr_reg(port_pin_override_pkg::DIRECTION_OFS, 8'h5A);
    wr_reg(port_pin_override_pkg::LATCH_OFS, 8'h0F);
    wr_reg(port_pin_override_pkg::PIN_READ_OFS, 8'hFF);
    settle("pin read toggle");
    for (int i = 0; i < 48; i++) begin
      r = {$urandom(), $urandom(), $urandom()};
      r[55:48] = 8'h00;
      if (i % 12 == 5) r[55:48] = 8'($urandom());
      cmd <= r[71:0];
      alt <= (i == 0) ? 8'hFF : 8'($urandom());
      @(posedge mclk);
      cmd[55:48] <= 8'h00;
      lat = lat ^ (r[55:48] & alt);
      sleeping <= 1'($urandom());
      mode <= 3'($urandom());
      pad <= 8'($urandom());
      apad <= 8'($urandom());
      aper <= 8'($urandom());
      wr_reg(port_pin_override_pkg::DIRECTION_OFS, 8'($urandom()));
      if (r[55:48] == 8'h00) wr_reg(port_pin_override_pkg::LATCH_OFS, 8'($urandom()));
      wr_reg(port_pin_override_pkg::PORT_CTRL_OFS, 8'($urandom()));
      if (i % 4 == 1) wr_reg(port_pin_override_pkg::PIN_READ_OFS, 8'($urandom()));
      settle("random");
      if (i % 8 == 7) begin
        repeat (6) @(posedge mclk);
        rd_all();
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
